/* File: inc/mit_pkg.sv */
// Purpose: shared constants and bus carriers of the macro instruction transform
// Assumes: 32-bit AXI4-Lite register access, one clock
// Notes: byte addresses are word aligned
package mit_pkg;

	// ----------------------------------------------------------------
	// bus shapes
	// ----------------------------------------------------------------
	localparam int MIT_ADDR_W = 8;

	typedef struct packed {
		logic awvalid;
		logic [MIT_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bready;
		logic arvalid;
		logic [MIT_ADDR_W-1:0] araddr;
		logic rready;
	} mit_axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} mit_axil_rsp_t;

	localparam logic [1:0] MIT_RESP_OKAY = 2'h0;
	localparam logic [1:0] MIT_RESP_DECERR = 2'h3;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [MIT_ADDR_W-1:0] MIT_OFF_CTRL = 8'h00;
	localparam logic [MIT_ADDR_W-1:0] MIT_OFF_STAT = 8'h04;
	localparam logic [MIT_ADDR_W-1:0] MIT_OFF_INSTR = 8'h08;
	localparam logic [MIT_ADDR_W-1:0] MIT_OFF_XFORM = 8'h0c;

	// control fields
	localparam int MIT_CTRL_DEC = 0;
	localparam int MIT_CTRL_DELTA = 1;
	localparam int MIT_CTRL_PREEN = 2;
	localparam int MIT_CTRL_INTEN = 3;
	localparam int MIT_CTRL_PAGE = 4;
	localparam int MIT_CTRL_W = 8;
	localparam logic [MIT_CTRL_W-1:0] MIT_CTRL_RST = 8'h00;

	// status fields
	localparam int MIT_STAT_PROT = 0;
	localparam int MIT_STAT_PAR = 1;
	localparam int MIT_STAT_HOLD = 2;
	localparam int MIT_STAT_INTEN = 3;

	// ----------------------------------------------------------------
	// transform positions
	// ----------------------------------------------------------------
	localparam logic [2:0] MIT_KN_DIRECT = 3'h6;
	localparam logic [2:0] MIT_KN_FLDSTR = 3'h7;
	localparam logic [2:0] MIT_KN_LOWBYTE = 3'h5;
	localparam int MIT_KN_EXT_N = 5;
	localparam int MIT_MA_EXT_N = 15;
	localparam logic [15:0] MIT_INSTR_RST = 16'h0000;
	localparam logic [7:0] MIT_BYTE_RST = 8'h00;

endpackage

/* File: verilog/mit_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are quasi-static levels or slow strobes
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module mit_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// data
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_q <= '0;
			q <= '0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end
endmodule
`default_nettype wire

/* File: verilog/mit_xform.sv */
// Purpose: macro instruction latch and micro address / K-N transforms
// Assumes: pin inputs asynchronous to aclk, held stable around strobes
// Notes: every pin input lags two clocks through the synchroniser
`timescale 1ns/1ps
`default_nettype none

module mit_xform
	import mit_pkg::*;
(
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire mit_pkg::mit_axil_req_t axil_req,
	output mit_pkg::mit_axil_rsp_t axil_rsp,
	// macro memory and strobes
	input wire logic [15:0] mem_data_in,
	input wire logic instr_reg_strobe,
	input wire logic transform_dispatch_cmd,
	// micro instruction
	input wire logic [31:24] uinst_bits,
	input wire logic seq_addr_mode_n,
	input wire logic zero_n_cmd,
	input wire logic zero_k_cmd,
	input wire logic zero_n_page_cmd,
	// transform sources
	input wire logic [MIT_MA_EXT_N-1:0][7:0] addr_src,
	input wire logic [MIT_KN_EXT_N-1:0][7:0] kn_src,
	input wire logic [7:0] field_store_source,
	// events
	input wire logic rom_access,
	input wire logic prot_violation,
	input wire logic mem_parity_err,
	// outputs
	output logic [0:15] instr_bits,
	output logic [7:0] addr_xform_out,
	output logic [7:0] kn_xform_out,
	output logic kn_select_enable_n,
	output logic delta_drive_en,
	output logic decimal_correct_act,
	output logic macro_int_en,
	output logic rom_page_guard_n,
	output logic [3:0] page_addr_n
);
	import mit_pkg::*;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] rev8(input logic [7:0] x);
		logic [7:0] r;
		r = '0;
		for (int i = 0; i < 8; i++) begin
			r[i] = x[7-i];
		end
		return r;
	endfunction

	function automatic logic reg_hit(input logic [MIT_ADDR_W-1:0] a);
		return (a == MIT_OFF_CTRL) || (a == MIT_OFF_STAT) ||
			(a == MIT_OFF_INSTR) || (a == MIT_OFF_XFORM);
	endfunction

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int SYNC_W = 16 + 1 + 1 + 8 + 1 + 3 + MIT_MA_EXT_N * 8 + MIT_KN_EXT_N * 8 + 8 + 3;

	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic [15:0] s_mem;
	logic s_strobe;
	logic s_dispatch;
	logic [7:0] s_u;
	logic s_seq_n;
	logic [2:0] s_zero;
	logic [MIT_MA_EXT_N-1:0][7:0] s_asrc;
	logic [MIT_KN_EXT_N-1:0][7:0] s_ksrc;
	logic [7:0] s_fld;
	logic s_rom;
	logic s_prot;
	logic s_par;

	// micro bits kept in a [7:0] vector with index 0 = bit 24
	assign sync_in = {mem_data_in, instr_reg_strobe, transform_dispatch_cmd,
		uinst_bits, seq_addr_mode_n, zero_n_cmd, zero_k_cmd, zero_n_page_cmd,
		addr_src, kn_src, field_store_source, rom_access, prot_violation, mem_parity_err};
	assign {s_mem, s_strobe, s_dispatch, s_u, s_seq_n, s_zero, s_asrc, s_ksrc, s_fld,
		s_rom, s_prot, s_par} = sync_out;

	mit_sync #(
		.W(SYNC_W)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.d(sync_in),
		.q(sync_out)
	);

	// s_u index n holds micro bit 24+n
	wire u28 = s_u[4];
	wire u29 = s_u[5];
	wire u30 = s_u[6];
	wire u31 = s_u[7];

	// ----------------------------------------------------------------
	// instruction latches
	// ----------------------------------------------------------------
	logic strobe_q;
	logic dispatch_q;
	logic [15:0] instr_q;
	logic [15:0] instr_d;
	logic [7:0] low_byte_q;
	logic [7:0] low_byte_d;

	wire instr_rise = s_strobe & ~strobe_q;
	wire low_byte_strobe = instr_rise & s_dispatch;
	wire dispatch_done = dispatch_q & ~s_dispatch;

	assign instr_d = instr_rise ? s_mem : instr_q;
	assign low_byte_d = low_byte_strobe ? s_mem[7:0] : low_byte_q;
	// packed copy reverses order: port bit 15 is register bit 0
	assign instr_bits = instr_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			strobe_q <= 1'b0;
			dispatch_q <= 1'b0;
			instr_q <= MIT_INSTR_RST;
			low_byte_q <= MIT_BYTE_RST;
		end else begin
			strobe_q <= s_strobe;
			dispatch_q <= s_dispatch;
			instr_q <= instr_d;
			low_byte_q <= low_byte_d;
		end
	end

	// ----------------------------------------------------------------
	// address transform
	// ----------------------------------------------------------------
	logic [15:0][7:0] asrc;
	logic [3:0] micro_sel;
	logic [3:0] instr_sel;
	logic [3:0] addr_sel;
	logic [7:0] addr_out_q;

	assign asrc = {low_byte_q, s_asrc};
	assign micro_sel = {u28, u29, u30, u31};
	// opcode nonzero picks storage decode, else sub-opcode decode
	assign instr_sel = (instr_q[15:12] != 4'h0) ? instr_q[15:12] : instr_q[11:8];
	assign addr_sel = s_dispatch ? instr_sel : micro_sel;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_out_q <= MIT_BYTE_RST;
		end else begin
			addr_out_q <= asrc[addr_sel];
		end
	end
	assign addr_xform_out = addr_out_q;

	// ----------------------------------------------------------------
	// K/N transform
	// ----------------------------------------------------------------
	logic [7:0][7:0] ksrc;
	logic [2:0] kn_sel;
	logic kn_en_n;
	logic [7:0] kn_out_q;
	logic kn_en_n_q;

	// direct source puts micro bit 24 in the msb
	assign ksrc = {s_fld, rev8(s_u), low_byte_q, s_ksrc};
	assign kn_en_n = |s_zero;
	assign kn_sel = !s_seq_n ? MIT_KN_DIRECT :
		(u28 ? {u29, u30, u31} : MIT_KN_FLDSTR);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			kn_out_q <= MIT_BYTE_RST;
			kn_en_n_q <= 1'b1;
		end else begin
			kn_out_q <= kn_en_n ? MIT_BYTE_RST : ksrc[kn_sel];
			kn_en_n_q <= kn_en_n;
		end
	end
	assign kn_xform_out = kn_out_q;
	assign kn_select_enable_n = kn_en_n_q;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic [MIT_ADDR_W-1:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	wire awready = ~aw_have_q & ~bvalid_q;
	wire wready = ~w_have_q & ~bvalid_q;
	wire arready = ~rvalid_q;
	wire aw_hs = axil_req.awvalid & awready;
	wire w_hs = axil_req.wvalid & wready;
	wire ar_hs = axil_req.arvalid & arready;
	wire [MIT_ADDR_W-1:0] wr_addr = aw_have_q ? aw_addr_q : axil_req.awaddr;
	wire [31:0] wr_data = w_have_q ? w_data_q : axil_req.wdata;
	wire [3:0] wr_strb = w_have_q ? w_strb_q : axil_req.wstrb;
	// both halves present, either order or together
	wire do_write = (aw_have_q | aw_hs) & (w_have_q | w_hs);
	wire wr_ctrl = do_write & (wr_addr == MIT_OFF_CTRL) & wr_strb[0];
	wire wr_stat = do_write & (wr_addr == MIT_OFF_STAT) & wr_strb[0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= '0;
			w_data_q <= '0;
			w_strb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= MIT_RESP_OKAY;
		end else begin
			aw_have_q <= ~do_write & (aw_have_q | aw_hs);
			w_have_q <= ~do_write & (w_have_q | w_hs);
			if (aw_hs) begin
				aw_addr_q <= axil_req.awaddr;
			end
			if (w_hs) begin
				w_data_q <= axil_req.wdata;
				w_strb_q <= axil_req.wstrb;
			end
			if (do_write) begin
				bvalid_q <= 1'b1;
				bresp_q <= reg_hit(wr_addr) ? MIT_RESP_OKAY : MIT_RESP_DECERR;
			end else if (axil_req.bready) begin
				bvalid_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// control and status
	// ----------------------------------------------------------------
	logic [MIT_CTRL_W-1:0] ctrl_q;
	logic prot_q;
	logic par_q;
	logic hold_q;
	logic int_en_q;
	logic dec_act_q;
	logic guard_n_q;
	logic [31:0] rd_word;

	// hardware set beats software clear in the same cycle
	wire prot_d = s_prot | (prot_q & ~(wr_stat & wr_data[MIT_STAT_PROT]));
	wire par_d = s_par | (par_q & ~(wr_stat & wr_data[MIT_STAT_PAR]));
	wire preen_set = wr_ctrl & wr_data[MIT_CTRL_PREEN];
	// a fresh pre-enable in the finishing cycle keeps the hold
	wire hold_d = preen_set | (hold_q & ~dispatch_done);
	// derived outputs track the new control word, no stale cycle after a write
	wire [MIT_CTRL_W-1:0] ctrl_d = wr_ctrl ? wr_data[MIT_CTRL_W-1:0] : ctrl_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= MIT_CTRL_RST;
			prot_q <= 1'b0;
			par_q <= 1'b0;
			hold_q <= 1'b0;
			int_en_q <= 1'b0;
			dec_act_q <= 1'b0;
			guard_n_q <= 1'b1;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= wr_data[MIT_CTRL_W-1:0];
			end
			prot_q <= prot_d;
			par_q <= par_d;
			hold_q <= hold_d;
			int_en_q <= ctrl_d[MIT_CTRL_INTEN] & ~hold_d;
			dec_act_q <= ctrl_d[MIT_CTRL_DEC] & ~ctrl_d[MIT_CTRL_DELTA];
			guard_n_q <= ~s_rom;
		end
	end

	assign delta_drive_en = ~ctrl_q[MIT_CTRL_DELTA];
	assign decimal_correct_act = dec_act_q;
	assign macro_int_en = int_en_q;
	assign rom_page_guard_n = guard_n_q;
	assign page_addr_n = ~ctrl_q[MIT_CTRL_PAGE +: 4];

	assign rd_word =
		(axil_req.araddr == MIT_OFF_CTRL) ? {24'h000000, ctrl_q} :
		(axil_req.araddr == MIT_OFF_STAT) ? {28'h0000000, int_en_q, hold_q, par_q, prot_q} :
		(axil_req.araddr == MIT_OFF_INSTR) ? {8'h00, low_byte_q, instr_q} :
		(axil_req.araddr == MIT_OFF_XFORM) ? {kn_out_q, addr_out_q, 5'h00, kn_sel, addr_sel, 4'h0} :
		32'h00000000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= MIT_RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_word;
			rresp_q <= reg_hit(axil_req.araddr) ? MIT_RESP_OKAY : MIT_RESP_DECERR;
		end else if (axil_req.rready) begin
			rvalid_q <= 1'b0;
		end
	end

	assign axil_rsp.awready = awready;
	assign axil_rsp.wready = wready;
	assign axil_rsp.bvalid = bvalid_q;
	assign axil_rsp.bresp = bresp_q;
	assign axil_rsp.arready = arready;
	assign axil_rsp.rvalid = rvalid_q;
	assign axil_rsp.rdata = rdata_q;
	assign axil_rsp.rresp = rresp_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	instr_capture_a: assert property (instr_rise |=> instr_q == $past(s_mem))
		else $error("instruction register missed a strobe");
	instr_hold_a: assert property (!instr_rise |=> $stable(instr_q))
		else $error("instruction register changed without a strobe");
	bit_order_a: assert property (instr_rise |=> instr_bits[15] == $past(mem_data_in[0], 3))
		else $error("instruction bit order wrong");
	low_byte_gate_a: assert property (!s_dispatch |=> $stable(low_byte_q))
		else $error("low byte updated outside dispatch");
	addr_micro_a: assert property (!s_dispatch |=> addr_out_q == $past(asrc[{u28, u29, u30, u31}]))
		else $error("address transform ignored micro select");
	addr_disp_a: assert property (s_dispatch && instr_q[15:12] == 4'h0 |-> addr_sel == instr_q[11:8])
		else $error("zero opcode dispatch select wrong");
	kn_zero_a: assert property (|s_zero |=> kn_out_q == 8'h00 && kn_select_enable_n)
		else $error("zero command did not clear K/N");
	kn_seq_a: assert property (!s_seq_n && !(|s_zero) |=> kn_out_q == rev8($past(s_u)))
		else $error("sequential mode did not load direct bits");
	kn_fld_a: assert property (s_seq_n && !u28 && !(|s_zero) |=> kn_out_q == $past(s_fld))
		else $error("field store source not selected");
	kn_micro_a: assert property (s_seq_n && u28 |-> kn_sel == {u29, u30, u31})
		else $error("K/N select not from micro bits");
	dec_gate_a: assert property (decimal_correct_act |-> delta_drive_en)
		else $error("decimal correction with delta disabled");
	prot_set_a: assert property (s_prot |=> prot_q)
		else $error("protect fault not flagged");
	parity_set_a: assert property (s_par |=> par_q)
		else $error("parity error not flagged");
	int_hold_a: assert property (hold_q && !dispatch_done |=> !macro_int_en)
		else $error("interrupt enabled during hold");
	page_guard_a: assert property (s_rom |=> !rom_page_guard_n)
		else $error("page guard not asserted on ROM access");
	bresp_hold_a: assert property (bvalid_q && !axil_req.bready |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped early");

	dispatch_load_c: cover property (low_byte_strobe ##1 s_dispatch);
	write_done_c: cover property (do_write ##1 bvalid_q);
	kn_clear_c: cover property (|s_zero ##1 !(|s_zero));
	hold_release_c: cover property (hold_q && dispatch_done);
endmodule
`default_nettype wire

/* File: tb/mit_host_model.sv */
// Purpose: host cpu model driving macro memory and micro instruction pins
// Assumes: tasks are entered from the bench just after a rising edge
// Notes: memory lines show the inverted word once the bus is released
`timescale 1ns/1ps
`default_nettype none
module mit_host_model (
	// clock
	input wire logic aclk,
	// pins toward the block
	output var logic [15:0] mem_data_in,
	output var logic instr_reg_strobe,
	output var logic transform_dispatch_cmd,
	output var logic [31:24] uinst_bits,
	output var logic seq_addr_mode_n,
	output var logic [2:0] zero_cmds
);
	initial begin
		mem_data_in = 16'h0000;
		instr_reg_strobe = 1'b0;
		transform_dispatch_cmd = 1'b0;
		uinst_bits = 8'h00;
		seq_addr_mode_n = 1'b1;
		zero_cmds = 3'h0;
	end
	// word set up three cycles before the strobe rises, held past its fall
	task automatic fetch(input logic [15:0] w);
		mem_data_in <= w;
		repeat (3) @(posedge aclk);
		instr_reg_strobe <= 1'b1;
		repeat (4) @(posedge aclk);
		instr_reg_strobe <= 1'b0;
		repeat (4) @(posedge aclk);
		// released lines must not look like the old word
		mem_data_in <= ~w;
	endtask
	task automatic set_dispatch(input logic v);
		transform_dispatch_cmd <= v;
	endtask
	// page lines are the host's to decode, low active
	task automatic set_uinst(input logic [31:24] u, input logic m, input logic [2:0] z);
		uinst_bits <= u;
		seq_addr_mode_n <= m;
		zero_cmds <= z;
	endtask
endmodule
`default_nettype wire

/* File: tb/macro_instruction_transform_tb.sv */
// Purpose: self-checking bench of the macro instruction transform
// Assumes: pins settle within six clocks of any change
// Notes: expectations come from a small model kept in this module
`timescale 1ns/1ps
`default_nettype none
module macro_instruction_transform_tb;
	import mit_pkg::*;
	logic aclk, aresetn, strb, dsp, mode_n, rom, disp, m_mode, m_hold;
	mit_axil_req_t req;
	mit_axil_rsp_t rsp;
	logic [15:0] mem_d, w, m_instr;
	logic [15:0] m_q[$];
	logic [31:24] ub, u;
	logic [2:0] zc, zero;
	logic [1:0] ev, m_flag;
	logic [14:0][7:0] a_src;
	logic [4:0][7:0] k_src;
	logic [7:0] fss, m_low, m_ctrl, addr_xf, kn_xf;
	logic [0:15] instr_bits;
	logic kn_en_n, delta_en, dec_act, int_en, guard_n;
	logic [3:0] page_n;
	logic [31:0] rs;
	int num_errors, checks;
	mit_host_model u_host (.aclk(aclk), .mem_data_in(mem_d), .instr_reg_strobe(strb),
		.transform_dispatch_cmd(dsp), .uinst_bits(ub), .seq_addr_mode_n(mode_n),
		.zero_cmds(zc));
	mit_xform u_dut (.aclk(aclk), .aresetn(aresetn), .axil_req(req), .axil_rsp(rsp),
		.mem_data_in(mem_d), .instr_reg_strobe(strb), .transform_dispatch_cmd(dsp),
		.uinst_bits(ub), .seq_addr_mode_n(mode_n), .zero_n_cmd(zc[0]), .zero_k_cmd(zc[1]),
		.zero_n_page_cmd(zc[2]), .addr_src(a_src), .kn_src(k_src), .field_store_source(fss),
		.rom_access(rom), .prot_violation(ev[0]), .mem_parity_err(ev[1]),
		.instr_bits(instr_bits), .addr_xform_out(addr_xf), .kn_xform_out(kn_xf),
		.kn_select_enable_n(kn_en_n), .delta_drive_en(delta_en),
		.decimal_correct_act(dec_act), .macro_int_en(int_en), .rom_page_guard_n(guard_n),
		.page_addr_n(page_n));
	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] nxt();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	task automatic end_of_test;
		$display("num_errors=%0d checks=%0d", num_errors, checks);
		if (num_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		if (n > 50) begin
			num_errors++;
			end_of_test();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, wh, b;
		logic [1:0] r;
		int n;
		b = 1'b0;
		n = 0;
		req.awvalid <= 1'b1;
		req.awaddr <= a;
		req.wvalid <= 1'b1;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.bready <= 1'b1;
		while (!b) begin
			@(negedge aclk);
			aw = req.awvalid & rsp.awready;
			wh = req.wvalid & rsp.wready;
			b = rsp.bvalid;
			r = rsp.bresp;
			@(posedge aclk);
			if (aw)
				req.awvalid <= 1'b0;
			if (wh)
				req.wvalid <= 1'b0;
			tick(++n);
		end
		req.bready <= 1'b0;
		chk(r, er);
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic ar, v;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		v = 1'b0;
		n = 0;
		req.arvalid <= 1'b1;
		req.araddr <= a;
		req.rready <= 1'b1;
		while (!v) begin
			@(negedge aclk);
			ar = req.arvalid & rsp.arready;
			v = rsp.rvalid;
			d = rsp.rdata;
			r = rsp.rresp;
			@(posedge aclk);
			if (ar)
				req.arvalid <= 1'b0;
			tick(++n);
		end
		req.rready <= 1'b0;
		@(posedge aclk);
		chk(d, ed);
		chk(r, er);
	endtask
	task automatic settle;
		repeat (6) @(posedge aclk);
	endtask
	task automatic rnd_src;
		for (int i = 0; i < 15; i++)
			a_src[i] <= 8'(nxt());
		for (int i = 0; i < 5; i++)
			k_src[i] <= 8'(nxt());
		fss <= 8'(nxt());
	endtask
	function automatic logic [7:0] exp_addr();
		logic [3:0] s;
		s = disp ? ((m_instr[15:12] != 4'h0) ? m_instr[15:12] : m_instr[11:8])
			: {u[28], u[29], u[30], u[31]};
		return (s == 4'hf) ? m_low : a_src[s];
	endfunction
	function automatic logic [7:0] exp_kn();
		logic [2:0] s;
		logic [7:0] r;
		s = !m_mode ? 3'h6 : (u[28] ? {u[29], u[30], u[31]} : 3'h7);
		for (int i = 0; i < 8; i++)
			r[7 - i] = u[24 + i];
		if (|zero)
			return 8'h00;
		if (s < 3'h5)
			return k_src[s];
		return (s == 3'h5) ? m_low : ((s == 3'h6) ? r : fss);
	endfunction
	task automatic chk_pins;
		chk(instr_bits, m_instr);
		chk({~m_ctrl[1]}, delta_en);
		chk({m_ctrl[0] & ~m_ctrl[1]}, dec_act);
		chk({m_ctrl[3] & ~m_hold}, int_en);
		chk(page_n, {~m_ctrl[7:4]});
		chk(addr_xf, exp_addr());
		chk(kn_xf, exp_kn());
		chk(kn_en_n, {|zero});
	endtask
	task automatic uinst(input logic [31:24] v, input logic m, input logic [2:0] z);
		u = v;
		m_mode = m;
		zero = z;
		u_host.set_uinst(v, m, z);
		settle();
		chk_pins();
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		aclk = 1'b0;
		forever #25 aclk = ~aclk;
	end
	initial begin
		aresetn = 1'b0;
		req = '0;
		rom = 1'b0;
		ev = 2'h0;
		rs = 32'h29;
		{a_src, k_src, fss} = '0;
		{m_instr, m_low, m_ctrl, m_flag, m_hold, disp, u, zero} = '0;
		m_mode = 1'b1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		settle();
		chk_pins();
		chk(guard_n, 1'b1);
		rd(MIT_OFF_CTRL, 32'h0, MIT_RESP_OKAY);
		rd(8'h10, 32'h0, MIT_RESP_DECERR);
		wr(MIT_OFF_INSTR, 32'hffff, MIT_RESP_OKAY);
		rd(MIT_OFF_INSTR, 32'h0, MIT_RESP_OKAY);
		for (int k = 0; k < 6; k++) begin
			m_ctrl = 8'(nxt());
			m_ctrl[2] = 1'b0;
			wr(MIT_OFF_CTRL, {24'h0, m_ctrl}, MIT_RESP_OKAY);
			settle();
			chk_pins();
			rd(MIT_OFF_CTRL, {24'h0, m_ctrl}, MIT_RESP_OKAY);
		end
		// fetches with and without dispatch, both opcode kinds
		for (int k = 0; k < 8; k++) begin
			w = 16'(nxt());
			if (k % 2 == 1)
				w[15:12] = 4'h0;
			if (k == 7)
				w[15:8] = 8'h0f;
			disp = 1'((k / 2) % 2);
			rnd_src();
			u_host.set_dispatch(disp);
			u_host.fetch(w);
			m_q.push_back(w);
			m_instr = m_q.pop_front();
			if (disp)
				m_low = w[7:0];
			settle();
			chk_pins();
			rd(MIT_OFF_INSTR, {8'h0, m_low, m_instr}, MIT_RESP_OKAY);
			disp = 1'b0;
			u_host.set_dispatch(1'b0);
			@(posedge aclk);
		end
		for (int k = 0; k < 32; k++)
			uinst({k[3:0], 4'(nxt())}, k[4], 3'h0);
		for (int k = 0; k < 3; k++)
			uinst(8'hf1, 1'b1, 3'(1 << k));
		uinst(8'h00, 1'b1, 3'h0);
		// sticky flags and their clearing
		for (int i = 1; i < 3; i++) begin
			ev <= 2'(i);
			@(posedge aclk);
			ev <= 2'h0;
			m_flag = 2'(i);
			settle();
			rd(MIT_OFF_STAT, {28'h0, m_ctrl[3], 1'b0, m_flag}, MIT_RESP_OKAY);
			wr(MIT_OFF_STAT, 32'(i), MIT_RESP_OKAY);
			m_flag = 2'h0;
			rd(MIT_OFF_STAT, {28'h0, m_ctrl[3], 3'h0}, MIT_RESP_OKAY);
		end
		rom <= 1'b1;
		settle();
		chk(guard_n, 1'b0);
		rom <= 1'b0;
		m_ctrl = 8'h0c;
		m_hold = 1'b1;
		wr(MIT_OFF_CTRL, 32'h0c, MIT_RESP_OKAY);
		settle();
		chk_pins();
		u_host.set_dispatch(1'b1);
		disp = 1'b1;
		settle();
		chk_pins();
		u_host.set_dispatch(1'b0);
		disp = 1'b0;
		m_hold = 1'b0;
		settle();
		chk_pins();
		end_of_test();
	end
endmodule
`default_nettype wire
